//--- dspwm_defs.svh
// Constants for the dual-slope symmetric PWM block.
`ifndef DSPWM_DEFS_SVH
`define DSPWM_DEFS_SVH
`define DSPWM_BOTTOM      16'h0000
`define DSPWM_MIN_TOP     16'h0003
`define DSPWM_MODE_ICR    4'h8
`define DSPWM_MODE_OCRA   4'h9
`define DSPWM_ACT_OFF     2'h0
`define DSPWM_ACT_TOGGLE  2'h1
`define DSPWM_ACT_NONINV  2'h2
`define DSPWM_ACT_INV     2'h3
`define DSPWM_PRE_1       3'h1
`define DSPWM_PRE_8       3'h2
`define DSPWM_PRE_64      3'h3
`define DSPWM_PRE_256     3'h4
`define DSPWM_PRE_1024    3'h5
`define DSPWM_DIV_8       10'h007
`define DSPWM_DIV_64      10'h03F
`define DSPWM_DIV_256     10'h0FF
`define DSPWM_DIV_1024    10'h3FF
`define DSPWM_RST_OUT     1'b0
`endif

//--- dspwm_pkg.sv
// Types shared by the dual-slope symmetric PWM block.
package dspwm_pkg;
  typedef enum logic {DSPWM_UP, DSPWM_DOWN} dspwm_dir_t;
  typedef struct packed {
    logic overflow;
    logic capture;
    logic match_a;
    logic match_b;
  } dspwm_flags_t;
  typedef struct packed {
    logic [9:0]   presc_cnt;
    logic         tick;
    logic [15:0]  count;
    dspwm_dir_t   dir;
    logic [15:0]  cmp_a;
    logic [15:0]  cmp_b;
    logic         out_a;
    logic         out_b;
    dspwm_flags_t flags;
    logic         pin_a;
    logic         pin_b;
    logic         pin_a_oe;
    logic         pin_b_oe;
  } dspwm_state_t;
endpackage

//--- dspwm_core.sv
// Phase-and-frequency-correct dual-slope PWM timer.
//
// Notes on behaviour
// RQ1: Counter climbs from zero to TOP, then falls back, reversing each end.
// RQ2: Mode 8 takes TOP from capture register, mode 9 from compare A.
// RQ3: Counter holds TOP for exactly one tick before counting down.
// RQ4: Non-inverting clears on up-match, sets on down-match; inverting opposite.
// RQ5: Action select two gives non-inverted PWM, three inverted PWM.
// RQ6: Compare output reaches pin only when its direction bit selects output.
// RQ7: Buffered compare values load into active registers only at zero.
// RQ8: Overflow flag sets in the tick the compare registers load at zero.
// RQ9: At TOP set compare-A flag or capture flag, per TOP source.
// RQ10: Each compare match sets that channel's match flag.
// RQ11: TOP values from three up to full sixteen-bit maximum are supported.
// RQ12: Software keeps TOP at or above all compare values.
// RQ13: Tick is I/O clock divided by 1, 8, 64, 256 or 1024.
// RQ14: Compare zero gives steady low, compare TOP high, non-inverted.
// RQ15: Everything runs on the I/O clock; tick is only an enable.
// RQ16: Software should use capture TOP when fixed, compare A when varying.
// RQ17: Action one toggles output A on match in this mode; B reserved.
// RQ18: Software writes land in buffers; matching uses active registers.
// RQ19: Flags and counter steps happen only on tick-enabled clock edges.
`timescale 1ns/1ps
`default_nettype none
`include "dspwm_defs.svh"
module dspwm_core (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // Configuration
  input  wire logic [3:0]            waveform_mode_select,
  input  wire logic [2:0]            prescale_select,
  input  wire logic [1:0]            output_action_select_a,
  input  wire logic [1:0]            output_action_select_b,
  input  wire logic                  pin_direction_bit_a,
  input  wire logic                  pin_direction_bit_b,
  // Software-written values
  input  wire logic [15:0]           capture_top_value,
  input  wire logic [15:0]           compare_a_buffer,
  input  wire logic [15:0]           compare_b_buffer,
  // Flag clear strobes, one bit per flag
  input  wire dspwm_pkg::dspwm_flags_t flag_clear,
  // Status
  output logic [15:0]                counter_value,
  output logic                       timer_tick,
  output dspwm_pkg::dspwm_flags_t    flags,
  output logic                       compare_output_a,
  output logic                       compare_output_b,
  // Pins
  output logic                       pin_a_out,
  output logic                       pin_a_oe,
  output logic                       pin_b_out,
  output logic                       pin_b_oe
);

  dspwm_pkg::dspwm_state_t st_r;
  dspwm_pkg::dspwm_state_t st_nxt;

  // --------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------

  // Returns the new output level for one channel on a compare match.
  function automatic logic match_level(
    input logic [1:0]            act,
    input dspwm_pkg::dspwm_dir_t dir,
    input logic                  cur,
    input logic                  can_toggle
  );
    logic lvl;
    lvl = cur;
    if (act == `DSPWM_ACT_NONINV) begin
      lvl = (dir == dspwm_pkg::DSPWM_DOWN); // [RQ4] [RQ5]
    end else if (act == `DSPWM_ACT_INV) begin
      lvl = (dir == dspwm_pkg::DSPWM_UP); // [RQ4] [RQ5]
    end else if (act == `DSPWM_ACT_TOGGLE && can_toggle) begin
      lvl = ~cur; // [RQ17]
    end
    return lvl;
  endfunction

  // True when the channel is connected to its pin in the current setting.
  function automatic logic connected(
    input logic [1:0] act,
    input logic       can_toggle
  );
    return (act == `DSPWM_ACT_NONINV) || (act == `DSPWM_ACT_INV) ||
           ((act == `DSPWM_ACT_TOGGLE) && can_toggle); // [RQ17]
  endfunction

  // Direction in force for a compare match. At BOTTOM the counter is
  // about to climb and at TOP about to fall, so a compare value equal
  // to either end leaves the output steady instead of flipping it.
  function automatic dspwm_pkg::dspwm_dir_t match_dir(
    input dspwm_pkg::dspwm_dir_t dir,
    input logic                  bottom,
    input logic                  top
  );
    dspwm_pkg::dspwm_dir_t md;
    md = dir;
    if (bottom) begin
      md = dspwm_pkg::DSPWM_UP; // [RQ14]
    end else if (top) begin
      md = dspwm_pkg::DSPWM_DOWN; // [RQ14]
    end
    return md;
  endfunction

  // One counter step in the given direction.
  function automatic logic [15:0] step_count(
    input logic [15:0]           cnt,
    input dspwm_pkg::dspwm_dir_t dir
  );
    logic [15:0] res;
    res = cnt + 16'h0001;
    if (dir == dspwm_pkg::DSPWM_DOWN) begin
      res = cnt - 16'h0001;
    end
    return res; // [RQ1]
  endfunction

  // True when the counter equals an active compare value.
  function automatic logic is_match(
    input logic [15:0] cnt,
    input logic [15:0] cmp
  );
    return (cnt == cmp); // [RQ10] [RQ18]
  endfunction

  // Limit of the prescale counter; zero gives a tick every cycle.
  function automatic logic [9:0] divider_limit(
    input logic [2:0] sel
  );
    logic [9:0] lim;
    lim = 10'h000;
    if (sel == `DSPWM_PRE_8) begin
      lim = `DSPWM_DIV_8;
    end else if (sel == `DSPWM_PRE_64) begin
      lim = `DSPWM_DIV_64;
    end else if (sel == `DSPWM_PRE_256) begin
      lim = `DSPWM_DIV_256;
    end else if (sel == `DSPWM_PRE_1024) begin
      lim = `DSPWM_DIV_1024;
    end
    return lim; // [RQ13]
  endfunction

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------

  logic [15:0]           top_val;
  logic                  top_from_a;
  logic                  mode_hi;
  logic                  at_top;
  logic                  at_bottom;
  logic                  div_done;
  logic [9:0]            div_max;
  dspwm_pkg::dspwm_dir_t cmp_dir;

  always_comb begin
    st_nxt     = st_r;
    mode_hi    = waveform_mode_select[3];
    top_from_a = (waveform_mode_select == `DSPWM_MODE_OCRA);
    // Compare A defines TOP from its active copy, so TOP shifts at zero.
    top_val    = top_from_a ? st_r.cmp_a : capture_top_value; // [RQ2] [RQ11]
    at_top     = (st_r.count == top_val);
    at_bottom  = (st_r.count == `DSPWM_BOTTOM);
    cmp_dir    = match_dir(st_r.dir, at_bottom, at_top);

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    // The tick is a one-cycle enable, never a clock of its own, so
    // every register below stays in the single system clock domain.
    div_max  = divider_limit(prescale_select);
    div_done = (st_r.presc_cnt >= div_max);
    st_nxt.tick = 1'b0;
    if (prescale_select == 3'h0) begin
      st_nxt.presc_cnt = 10'h000;
    end else if (div_done) begin
      st_nxt.presc_cnt = 10'h000;
      st_nxt.tick      = 1'b1; // [RQ13] [RQ15]
    end else begin
      st_nxt.presc_cnt = st_r.presc_cnt + 10'h001;
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    // Software clears first; a set below in the same cycle wins.
    st_nxt.flags = st_r.flags & ~flag_clear;

    if (st_r.tick) begin // [RQ19]
      // ----------------------------------------------------------
      // Counter direction and stepping
      // ----------------------------------------------------------
      case (st_r.dir)
        dspwm_pkg::DSPWM_UP: begin
          if (at_top || st_r.count > top_val) begin
            st_nxt.dir   = dspwm_pkg::DSPWM_DOWN; // [RQ3]
            st_nxt.count = step_count(st_r.count,
                                      dspwm_pkg::DSPWM_DOWN); // [RQ1]
          end else begin
            st_nxt.count = step_count(st_r.count,
                                      dspwm_pkg::DSPWM_UP); // [RQ1]
          end
        end
        dspwm_pkg::DSPWM_DOWN: begin
          if (at_bottom) begin
            st_nxt.dir   = dspwm_pkg::DSPWM_UP;
            st_nxt.count = step_count(st_r.count,
                                      dspwm_pkg::DSPWM_UP); // [RQ1]
          end else begin
            st_nxt.count = step_count(st_r.count,
                                      dspwm_pkg::DSPWM_DOWN); // [RQ1]
          end
        end
        default: st_nxt.dir = dspwm_pkg::DSPWM_UP;
      endcase

      // ----------------------------------------------------------
      // Buffer transfer and overflow at BOTTOM
      // ----------------------------------------------------------
      if (at_bottom) begin
        st_nxt.cmp_a          = compare_a_buffer; // [RQ7] [RQ18]
        st_nxt.cmp_b          = compare_b_buffer; // [RQ7] [RQ18]
        st_nxt.flags.overflow = 1'b1; // [RQ8]
      end

      // ----------------------------------------------------------
      // TOP flags
      // ----------------------------------------------------------
      if (at_top) begin
        if (top_from_a) begin
          st_nxt.flags.match_a = 1'b1; // [RQ9]
        end else begin
          st_nxt.flags.capture = 1'b1; // [RQ9]
        end
      end

      // ----------------------------------------------------------
      // Compare matches against the active registers only
      // ----------------------------------------------------------
      // A compare value above TOP never matches; software must avoid it.
      if (is_match(st_r.count, st_r.cmp_a)) begin // [RQ18]
        st_nxt.flags.match_a = 1'b1; // [RQ10]
        st_nxt.out_a = match_level(output_action_select_a, cmp_dir,
                                   st_r.out_a, mode_hi); // [RQ14]
      end
      if (is_match(st_r.count, st_r.cmp_b)) begin // [RQ18]
        st_nxt.flags.match_b = 1'b1; // [RQ10]
        st_nxt.out_b = match_level(output_action_select_b, cmp_dir,
                                   st_r.out_b, 1'b0); // [RQ14]
      end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Pin drive follows the connection and the direction bit.
    st_nxt.pin_a    = st_nxt.out_a;
    st_nxt.pin_b    = st_nxt.out_b;
    st_nxt.pin_a_oe = pin_direction_bit_a &&
                      connected(output_action_select_a, mode_hi); // [RQ6]
    st_nxt.pin_b_oe = pin_direction_bit_b &&
                      connected(output_action_select_b, 1'b0); // [RQ6]
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt; // [RQ15]
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------

  // Every output is a field of the state register.
  assign counter_value    = st_r.count;
  assign timer_tick       = st_r.tick;
  assign flags            = st_r.flags;
  assign compare_output_a = st_r.out_a;
  assign compare_output_b = st_r.out_b;
  assign pin_a_out        = st_r.pin_a;
  assign pin_a_oe         = st_r.pin_a_oe;
  assign pin_b_out        = st_r.pin_b;
  assign pin_b_oe         = st_r.pin_b_oe;

endmodule
`default_nettype wire

//--- dspwm_asserts.sv
// Concurrent checks on the ports of the dual-slope PWM block.
`timescale 1ns/1ps
`default_nettype none
module dspwm_asserts (
  // Clock, reset and configuration
  input wire logic                    clk_sys,
  input wire logic                    rst_b,
  input wire logic [3:0]              waveform_mode_select,
  input wire logic [2:0]              prescale_select,
  input wire logic [1:0]              output_action_select_b,
  input wire logic                    pin_direction_bit_a,
  input wire logic [15:0]             capture_top_value,
  // Status and outputs
  input wire logic [15:0]             counter_value,
  input wire logic                    timer_tick,
  input wire dspwm_pkg::dspwm_flags_t flags,
  input wire logic                    compare_output_b,
  input wire logic                    pin_a_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence gap_of_eight;
    !timer_tick[*7] ##1 timer_tick;
  endsequence
  a_idle_hold: assert property (!timer_tick |=> $stable(counter_value))
    else $error("counter moved without a tick");
  a_flag_idle: assert property (!timer_tick |=> (flags & ~$past(flags)) == 4'h0)
    else $error("flag rose without a tick");
  a_step_one: assert property (timer_tick |=>
    counter_value == $past(counter_value) + 16'h0001 ||
    counter_value == $past(counter_value) - 16'h0001)
    else $error("counter did not step by one");
  a_overflow_bottom: assert property ($rose(flags.overflow) |->
    $past(counter_value) == 16'h0000 && $past(timer_tick))
    else $error("overflow flag away from zero");
  a_capture_top: assert property ($rose(flags.capture) |->
    $past(counter_value) == $past(capture_top_value) &&
    $past(waveform_mode_select) == 4'h8)
    else $error("capture flag away from top");
  a_match_tick: assert property ($rose(flags.match_b) |-> $past(timer_tick))
    else $error("match flag without a tick");
  a_out_tick: assert property ($changed(compare_output_b) &&
    $stable(output_action_select_b) |-> $past(timer_tick))
    else $error("output changed without a tick");
  a_pin_enable: assert property (pin_a_oe |-> $past(pin_direction_bit_a))
    else $error("pin driven while set as input");
  a_div_eight: assert property ($rose(timer_tick) &&
    prescale_select == 3'h2 |=> gap_of_eight)
    else $error("tick spacing wrong at divide by eight");
endmodule
bind dspwm_core dspwm_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .waveform_mode_select(waveform_mode_select),
  .prescale_select(prescale_select),
  .output_action_select_b(output_action_select_b),
  .pin_direction_bit_a(pin_direction_bit_a),
  .capture_top_value(capture_top_value), .counter_value(counter_value),
  .timer_tick(timer_tick), .flags(flags),
  .compare_output_b(compare_output_b), .pin_a_oe(pin_a_oe));
`default_nettype wire

//--- dspwm_core_test.sv
// Self-checking bench for the dual-slope PWM block.
`timescale 1ns/1ps
`default_nettype none
module dspwm_core_test;
  logic                    clk_sys = 1'b0;
  logic                    rst_b = 1'b0;
  logic [3:0]              mode = 4'h8;
  logic [2:0]              presc = 3'h1;
  logic [15:0]             buf_a = 16'h0002;
  logic                    dir_a = 1'b1;
  dspwm_pkg::dspwm_flags_t clr = 4'h0;
  logic [15:0]             cnt;
  logic                    tick, oa, ob, pa, pae, pb, pbe;
  dspwm_pkg::dspwm_flags_t flg;
  int                      bad_count = 0;
  int                      compares = 0;
  int                      n;
  logic [15:0]             top_seen;
  dspwm_core dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .waveform_mode_select(mode), .prescale_select(presc),
    .output_action_select_a(2'h2), .output_action_select_b(2'h3),
    .pin_direction_bit_a(dir_a), .pin_direction_bit_b(1'b0),
    .capture_top_value(16'h0004), .compare_a_buffer(buf_a),
    .compare_b_buffer(16'h0001), .flag_clear(clr), .counter_value(cnt),
    .timer_tick(tick), .flags(flg), .compare_output_a(oa),
    .compare_output_b(ob), .pin_a_out(pa), .pin_a_oe(pae),
    .pin_b_out(pb), .pin_b_oe(pbe));
  initial forever #50 clk_sys = ~clk_sys;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic nx;
    @(negedge clk_sys);
  endtask
  // Walks from TOP four down to zero and 17 cycles on, with both output polarities.
  task automatic run_sweep;
    for (n = 0; n < 200 && cnt !== 16'h0004; n++) nx();
    chk(cnt, 16'h0004);
    chk(oa, 1'b0);
    chk(ob, 1'b1);
    nx(); chk(cnt, 16'h0003);
    chk(flg, 4'hF);
    clr = 4'hF;
    buf_a = 16'h0000;
    nx(); clr = 4'h0;
    chk(cnt, 16'h0002);
    nx(); chk(oa, 1'b1);
    chk(flg, 4'h2);
    nx(); chk(cnt, 16'h0000);
    chk(ob, 1'b0);
    chk({pa, pae, pb, pbe}, 4'b1100);
    nx(); chk(flg, 4'hB);
    repeat (8) nx();
    for (n = 0; n < 8; n++) begin
      chk(oa, 1'b0);
      nx();
    end
  endtask
  // Takes TOP from compare A and looks for the highest count.
  task automatic run_mode9;
    buf_a = 16'h0005;
    repeat (10) nx();
    mode = 4'h9;
    repeat (20) nx();
    clr = 4'hF;
    nx(); clr = 4'h0;
    top_seen = 16'h0000;
    repeat (12) begin
      if (cnt > top_seen) top_seen = cnt;
      nx();
    end
    chk(top_seen, 16'h0005);
    chk(flg, 4'hB);
  endtask
  task automatic run_div8;
    presc = 3'h2;
    for (n = 0; n < 40 && tick !== 1'b1; n++) nx();
    n = 0;
    do begin
      nx(); n++;
    end while (tick !== 1'b1 && n < 40);
    chk(16'(n), 16'h0008);
  endtask
  // Turns channel A's pin to input and back.
  task automatic run_pin;
    dir_a = 1'b0;
    nx(); chk(pae, 1'b0);
    dir_a = 1'b1;
    nx(); chk(pae, 1'b1);
  endtask
  initial begin
    repeat (8) nx();
    chk(cnt, 16'h0000);
    rst_b = 1'b1;
    run_sweep();
    run_mode9();
    run_div8();
    run_pin();
    print_verdict();
  end
  initial begin
    #200_000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
